// >>> tars_cfg.svh
// tars_cfg.svh: offsets, field positions, reset values and timing counts
// assumes a 250 MHz clock and a 32-bit classic wishbone slave port
`ifndef TARS_CFG_SVH
`define TARS_CFG_SVH
// ==========================================================
// timing
`define TARS_CLK_PS        4000
`define TARS_TICK_MS       100
`define TARS_TICK_CYC      ((`TARS_TICK_MS * 64'd1000000000) / `TARS_CLK_PS)
`define TARS_FREE_S        300
`define TARS_FREE_TICKS    16'((`TARS_FREE_S * 1000) / `TARS_TICK_MS)
// ==========================================================
// register byte offsets
`define TARS_OFS_CTRL      8'h00
`define TARS_OFS_LIMIT     8'h04
`define TARS_OFS_MASK_A    8'h08
`define TARS_OFS_MASK_B    8'h0C
`define TARS_OFS_INIT_A    8'h10
`define TARS_OFS_ATT_A     8'h14
`define TARS_OFS_INIT_B    8'h18
`define TARS_OFS_ATT_B     8'h1C
`define TARS_OFS_STATUS    8'h20
`define TARS_OFS_TLEFT     8'h24
`define TARS_OFS_IRQ_STAT  8'h28
`define TARS_OFS_IRQ_MASK  8'h2C
// ==========================================================
// fields and reset values
`define TARS_LIMIT_MIN     4'h1
`define TARS_LIMIT_MAX     4'hA
`define TARS_RST_LIMIT     4'h5
`define TARS_RST_INIT_A    13'h0064
`define TARS_RST_ATT_A     13'h0064
`define TARS_RST_INIT_B    13'h0001
`define TARS_RST_ATT_B     13'h0001
`define TARS_DLY_MAX       13'h1770
`define TARS_IRQ_RESTART   0
`define TARS_IRQ_LOCKOUT   1
`define TARS_IRQ_CLEARED   2
`endif

// >>> tars_pkg.sv
// tars_pkg.sv: types shared by the restart sequencer
// assumes tars_cfg.svh for all numeric constants
package tars_pkg;
    // ==========================================================
    // carriers
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } tars_wb_req_t;

    typedef struct packed {
        logic [15:0] trip;
        logic        all_clear;
        logic        ext_reset;
        logic        comms_seq;
    } tars_drv_t;

    // ==========================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_WAIT,
        ST_TIMING,
        ST_RESTART,
        ST_LOCK
    } tars_state_t;
endpackage : tars_pkg

// >>> tars_top.sv
// tars_top.sv: automatic trip reset and restart sequencer with wishbone registers
// assumes drive logic on the same clock; trip is one-hot, ext_reset a pulse
//
// The implementer's own choices: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`include "tars_cfg.svh"
module tars_top #(
    parameter longint TICK_CYC = `TARS_TICK_CYC
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire tars_pkg::tars_wb_req_t wb_i,
    output logic                        wb_ack_o,
    output logic [31:0]                 wb_dat_o,
    input  wire tars_pkg::tars_drv_t    drv_i,
    output logic                        restart_req_o,
    output logic                        pending_o,
    output logic                        restart_in_progress_flag,
    output logic [3:0]                  attempts_left_o,
    output logic [12:0]                 time_left_o,
    output logic                        irq_o
);
    import tars_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
        wmerge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction : wmerge

    function automatic logic [3:0] clamp_lim(input logic [15:0] v);
        if (v < 16'(`TARS_LIMIT_MIN))
            clamp_lim = `TARS_LIMIT_MIN;
        else if (v > 16'(`TARS_LIMIT_MAX))
            clamp_lim = `TARS_LIMIT_MAX;
        else
            clamp_lim = v[3:0];
    endfunction : clamp_lim

    function automatic logic [12:0] clamp_dly(input logic [15:0] v);
        clamp_dly = (v > 16'(`TARS_DLY_MAX)) ? `TARS_DLY_MAX : v[12:0];
    endfunction : clamp_dly

    // ==========================================================
    // registers
    logic              en_r;
    logic [3:0]        limit_r;
    logic [15:0]       mask_a_r;
    logic [15:0]       mask_b_r;
    logic [12:0]       init_a_r;
    logic [12:0]       att_a_r;
    logic [12:0]       init_b_r;
    logic [12:0]       att_b_r;
    logic [2:0]        irq_stat_r;
    logic [2:0]        irq_mask_r;
    logic              ack_r;
    logic [31:0]       rdat_r;
    logic [31:0]       rd_nxt;
    tars_state_t       state_r;
    tars_state_t       state_nxt;
    logic [3:0]        used_r;
    logic [12:0]       tleft_r;
    logic [15:0]       free_r;
    logic [24:0]       tick_cnt_r;
    logic              tick_r;
    logic              use_a_r;
    logic              restart_r;
    logic              pending_r;
    logic              busy_r;
    logic [3:0]        left_r;
    logic              irq_r;
    logic              hit;
    logic              wr;
    logic              allow;
    logic              hit_a;
    logic              hit_b;
    logic              can_try;
    logic              to_timing;
    logic              to_restart;
    logic              free_done;
    logic [15:0]       free_thr;
    logic [12:0]       dly_sel;
    logic [2:0]        ev;

    assign hit = wb_i.cyc && wb_i.stb && !ack_r;
    assign wr  = hit && wb_i.we;

    // ==========================================================
    // wishbone slave: one wait state, unmapped reads return zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            ack_r <= hit;
            if (hit)
                rdat_r <= rd_nxt;
        end
    end

    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (wb_i.adr)
            `TARS_OFS_CTRL:     rd_nxt = {31'h0, en_r};
            `TARS_OFS_LIMIT:    rd_nxt = {28'h0, limit_r};
            `TARS_OFS_MASK_A:   rd_nxt = {16'h0, mask_a_r};
            `TARS_OFS_MASK_B:   rd_nxt = {16'h0, mask_b_r};
            `TARS_OFS_INIT_A:   rd_nxt = {19'h0, init_a_r};
            `TARS_OFS_ATT_A:    rd_nxt = {19'h0, att_a_r};
            `TARS_OFS_INIT_B:   rd_nxt = {19'h0, init_b_r};
            `TARS_OFS_ATT_B:    rd_nxt = {19'h0, att_b_r};
            `TARS_OFS_STATUS:   rd_nxt = {20'h0, left_r, 2'h0, busy_r, pending_r, 1'b0, state_r};
            `TARS_OFS_TLEFT:    rd_nxt = {19'h0, tleft_r};
            `TARS_OFS_IRQ_STAT: rd_nxt = {29'h0, irq_stat_r};
            `TARS_OFS_IRQ_MASK: rd_nxt = {29'h0, irq_mask_r};
            default:            rd_nxt = 32'h0000_0000;
        endcase
    end

    // settings; delays are 0.1 s units, clamped to 600.0 s
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_r       <= 1'b0;
            limit_r    <= `TARS_RST_LIMIT;
            mask_a_r   <= 16'h0000;
            mask_b_r   <= 16'h0000;
            init_a_r   <= `TARS_RST_INIT_A;
            att_a_r    <= `TARS_RST_ATT_A;
            init_b_r   <= `TARS_RST_INIT_B;
            att_b_r    <= `TARS_RST_ATT_B;
            irq_mask_r <= 3'h0;
        end else if (wr) begin
            unique case (wb_i.adr)
                `TARS_OFS_CTRL:     if (wb_i.sel[0]) en_r <= wb_i.dat[0];
                `TARS_OFS_LIMIT:    limit_r  <= clamp_lim(wmerge({12'h0, limit_r}, wb_i.dat, wb_i.sel));
                `TARS_OFS_MASK_A:   mask_a_r <= wmerge(mask_a_r, wb_i.dat, wb_i.sel);
                `TARS_OFS_MASK_B:   mask_b_r <= wmerge(mask_b_r, wb_i.dat, wb_i.sel);
                `TARS_OFS_INIT_A:   init_a_r <= clamp_dly(wmerge({3'h0, init_a_r}, wb_i.dat, wb_i.sel));
                `TARS_OFS_ATT_A:    att_a_r  <= clamp_dly(wmerge({3'h0, att_a_r}, wb_i.dat, wb_i.sel));
                `TARS_OFS_INIT_B:   init_b_r <= clamp_dly(wmerge({3'h0, init_b_r}, wb_i.dat, wb_i.sel));
                `TARS_OFS_ATT_B:    att_b_r  <= clamp_dly(wmerge({3'h0, att_b_r}, wb_i.dat, wb_i.sel));
                `TARS_OFS_IRQ_MASK: if (wb_i.sel[0]) irq_mask_r <= wb_i.dat[2:0];
                default:            ;
            endcase
        end
    end

    // ==========================================================
    // 0.1 s time base
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_r <= 25'h0;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == 25'(TICK_CYC - 1)) begin
            tick_cnt_r <= 25'h0;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 25'h1;
            tick_r     <= 1'b0;
        end
    end

    // ==========================================================
    // sequencer
    assign allow   = en_r && !drv_i.comms_seq;
    assign hit_a   = |(drv_i.trip & mask_a_r);
    assign hit_b   = |(drv_i.trip & mask_b_r);
    assign can_try = allow && (hit_a || hit_b) && (used_r < limit_r);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (drv_i.trip != 16'h0000)
                    state_nxt = can_try ? ST_WAIT : ST_LOCK;
            end
            ST_WAIT: begin
                if (!allow)
                    state_nxt = ST_LOCK;
                else if (drv_i.all_clear)
                    state_nxt = ST_TIMING;
            end
            ST_TIMING: begin
                if (!allow)
                    state_nxt = ST_LOCK;
                else if (!drv_i.all_clear)
                    state_nxt = ST_WAIT;
                else if (tleft_r == 13'h0)
                    state_nxt = ST_RESTART;
            end
            ST_RESTART: begin
                if (drv_i.trip == 16'h0000)
                    state_nxt = ST_IDLE;
            end
            ST_LOCK: state_nxt = ST_LOCK;
        endcase
        if (drv_i.ext_reset)
            state_nxt = ST_IDLE;
    end

    assign to_timing  = (state_r == ST_WAIT) && (state_nxt == ST_TIMING);
    assign to_restart = (state_r == ST_TIMING) && (state_nxt == ST_RESTART);

    // mask A wins when a trip is in both masks
    always_comb begin
        if (use_a_r)
            dly_sel = (used_r == 4'h0) ? init_a_r : att_a_r;
        else
            dly_sel = (used_r == 4'h0) ? init_b_r : att_b_r;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            use_a_r <= 1'b0;
        else if (state_r == ST_IDLE && drv_i.trip != 16'h0000)
            use_a_r <= hit_a;
    end

    // countdown is loaded once per clearing, so later edits of the delays leave it alone
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            tleft_r <= 13'h0;
        else if (to_timing)
            tleft_r <= dly_sel;
        else if (state_r == ST_TIMING && tick_r && tleft_r != 13'h0)
            tleft_r <= tleft_r - 13'h1;
        else if (state_r != ST_TIMING)
            tleft_r <= 13'h0;
    end

    // trip-free window: longer of 5 minutes or 4x attempt delay A
    assign free_thr  = (({3'h0, att_a_r} << 2) > `TARS_FREE_TICKS) ? ({3'h0, att_a_r} << 2) : `TARS_FREE_TICKS;
    assign free_done = (state_r == ST_IDLE) && (used_r != 4'h0) && (free_r >= free_thr);

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            free_r <= 16'h0;
        else if (state_r != ST_IDLE || drv_i.trip != 16'h0000 || used_r == 4'h0)
            free_r <= 16'h0;
        else if (tick_r && !free_done)
            free_r <= free_r + 16'h1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            used_r <= 4'h0;
        else if (drv_i.ext_reset)
            used_r <= 4'h0;
        else if (free_done)
            used_r <= 4'h0;
        else if (to_restart)
            used_r <= used_r + 4'h1;
    end

    // ==========================================================
    // flag outputs, all registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            restart_r <= 1'b0;
            pending_r <= 1'b0;
            busy_r    <= 1'b0;
            left_r    <= `TARS_RST_LIMIT;
        end else begin
            restart_r <= (state_nxt == ST_RESTART);
            pending_r <= (state_nxt == ST_WAIT) || (state_nxt == ST_TIMING);
            busy_r    <= (state_nxt == ST_RESTART);
            left_r    <= (used_r >= limit_r) ? 4'h0 : limit_r - used_r;
        end
    end

    // ==========================================================
    // interrupts: set wins over a same-cycle write-one clear
    assign ev[`TARS_IRQ_RESTART] = to_restart;
    assign ev[`TARS_IRQ_LOCKOUT] = (state_r != ST_LOCK) && (state_nxt == ST_LOCK);
    assign ev[`TARS_IRQ_CLEARED] = free_done;

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            irq_stat_r <= 3'h0;
        else if (wr && wb_i.adr == `TARS_OFS_IRQ_STAT && wb_i.sel[0])
            irq_stat_r <= (irq_stat_r & ~wb_i.dat[2:0]) | ev;
        else
            irq_stat_r <= irq_stat_r | ev;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            irq_r <= 1'b0;
        else
            irq_r <= |(irq_stat_r & irq_mask_r);
    end

    assign wb_ack_o                 = ack_r;
    assign wb_dat_o                 = rdat_r;
    assign restart_req_o            = restart_r;
    assign pending_o                = pending_r;
    assign restart_in_progress_flag = busy_r;
    assign attempts_left_o          = left_r;
    assign time_left_o              = tleft_r;
    assign irq_o                    = irq_r;

    // ==========================================================
    // checks
    en_gate_a: assert property (@(posedge clk) disable iff (rst)
        $rose(restart_r) |-> $past(en_r)) else $error("restart while disabled");
    comms_inhib_a: assert property (@(posedge clk) disable iff (rst)
        $rose(restart_r) |-> !$past(drv_i.comms_seq)) else $error("restart in comms mode");
    used_limit_a: assert property (@(posedge clk) disable iff (rst)
        to_restart |-> used_r < limit_r) else $error("attempt beyond limit");
    lock_hold_a: assert property (@(posedge clk) disable iff (rst)
        state_r == ST_LOCK && !drv_i.ext_reset |=> state_r == ST_LOCK && !restart_r) else $error("lock released");
    reset_clear_a: assert property (@(posedge clk) disable iff (rst)
        drv_i.ext_reset |=> used_r == 4'h0 && state_r == ST_IDLE) else $error("reset did not clear");
    free_clear_a: assert property (@(posedge clk) disable iff (rst)
        $fell(used_r != 4'h0) && !$past(drv_i.ext_reset)
        |-> $past(free_r) >= 16'(`TARS_FREE_TICKS) && $past(free_r) >= ($past({3'h0, att_a_r}) << 2))
        else $error("count cleared early");
    count_down_a: assert property (@(posedge clk) disable iff (rst)
        state_r == ST_TIMING && state_nxt == ST_TIMING && tick_r && tleft_r != 13'h0
        |=> tleft_r == $past(tleft_r) - 13'h1) else $error("countdown wrong");
    pend_flag_a: assert property (@(posedge clk) disable iff (rst)
        pending_r == (state_r == ST_WAIT || state_r == ST_TIMING))
        else $error("pending flag wrong");
    busy_flag_a: assert property (@(posedge clk) disable iff (rst)
        busy_r == (state_r == ST_RESTART) && busy_r == restart_r && !(busy_r && pending_r))
        else $error("restart_in_progress_flag flag wrong");
    left_out_a: assert property (@(posedge clk) disable iff (rst)
        $stable(used_r) && $stable(limit_r)
        |=> left_r == (($past(used_r) >= $past(limit_r)) ? 4'h0 : $past(limit_r) - $past(used_r)))
        else $error("left wrong");
    prio_a_a: assert property (@(posedge clk) disable iff (rst)
        state_r == ST_IDLE && drv_i.trip != 16'h0000 && hit_a |=> use_a_r) else $error("mask a lost priority");
endmodule : tars_top

// >>> tars_drv_model.sv
// tars_drv_model.sv: drive-side trip detection and run sequencing model
// assumes the bench commands trips, resets and comms mode on the shared clock
`timescale 1ns/10ps
module tars_drv_model (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic [15:0]         trip_set,
    input  wire logic                fire,
    input  wire logic [7:0]          clr_dly,
    input  wire logic [3:0]          slow,
    input  wire logic                ext_req,
    input  wire logic                comms,
    input  wire logic                restart_req,
    output tars_pkg::tars_drv_t      drv
);
    import tars_pkg::*;
    logic [7:0] cnt_r;
    logic [3:0] hold_r;
    // ==========================================================
    // trip word, clear level, reset pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drv <= '0;
            cnt_r <= '0;
            hold_r <= '0;
        end else begin
            drv.comms_seq <= comms;
            drv.ext_reset <= ext_req;
            if (fire) begin
                drv.trip <= trip_set;
                drv.all_clear <= 1'b0;
                cnt_r <= clr_dly;
                hold_r <= slow;
            end else if (ext_req) begin
                drv.trip <= '0;
                drv.all_clear <= 1'b1;
            end else if (drv.trip != '0 && !drv.all_clear) begin
                if (cnt_r == '0) begin
                    drv.all_clear <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 8'h01;
                end
            end else if (restart_req) begin
                // a slow drive keeps its trip word up a while after the request
                if (hold_r == '0) begin
                    drv.trip <= '0;
                end else begin
                    hold_r <= hold_r - 4'h1;
                end
            end
        end
    end
endmodule : tars_drv_model

// >>> tars_top_bench.sv
// tars_top_bench.sv: self-checking bench for the restart sequencer
// assumes tars_top with a 4-cycle tick and the drive model on the far side
`timescale 1ns/10ps
`include "tars_cfg.svh"
module tars_top_bench;
    import tars_pkg::*;
    localparam int TK = 4;
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    tars_wb_req_t  wb_r = '0;
    tars_drv_t     drv;
    logic          wb_ack_o;
    logic [31:0]   wb_dat_o;
    logic          restart_req_o;
    logic          pending_o;
    logic          restart_in_progress_flag;
    logic [3:0]    attempts_left_o;
    logic [12:0]   time_left_o;
    logic          irq_o;
    logic [15:0]   trip_q = '0;
    logic          fire_q = 1'b0;
    logic [7:0]    clr_q = '0;
    logic [3:0]    slow_q = '0;
    logic          ext_q = 1'b0;
    logic          comms_q = 1'b0;
    logic [31:0]   expq[$];
    int            seed = 32'hCD8C;
    int            errors = 0;
    int            cmp_count = 0;
    int            cycles = 0;

    always #2 clk = ~clk;

    tars_top #(.TICK_CYC(TK)) i_tars_top (.clk(clk), .rst(rst), .wb_i(wb_r), .wb_ack_o(wb_ack_o),
        .wb_dat_o(wb_dat_o), .drv_i(drv), .restart_req_o(restart_req_o), .pending_o(pending_o),
        .restart_in_progress_flag(restart_in_progress_flag), .attempts_left_o(attempts_left_o),
        .time_left_o(time_left_o), .irq_o(irq_o));
    tars_drv_model i_tars_drv_model (.clk(clk), .rst(rst), .trip_set(trip_q), .fire(fire_q),
        .clr_dly(clr_q), .slow(slow_q), .ext_req(ext_q), .comms(comms_q),
        .restart_req(restart_req_o), .drv(drv));

    // ==========================================================
    // compare, bus cycle, closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // for a read, d is the expected word; the monitor compares it on ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_r <= '{1'b1, 1'b1, w, a, 4'hF, d};
        if (!w) expq.push_back(d);
        @(posedge clk);
        while (wb_ack_o !== 1'b1) @(posedge clk);
        wb_r <= '0;
        @(posedge clk);
    endtask : wb

    task automatic summarize();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize

    always @(posedge clk) begin
        if (wb_ack_o === 1'b1 && !wb_r.we) begin
            if (expq.size() == 0) chk(32'hDEAD, 32'h0);
            else chk(wb_dat_o, expq.pop_front());
        end
    end

    // hang guard well above the longest trip-free wait
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            summarize();
        end
    end

    // ==========================================================
    // scenario helpers
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic trip(input logic [15:0] t);
        @(posedge clk);
        trip_q <= t;
        fire_q <= 1'b1;
        clr_q <= 8'($random(seed)) & 8'h0F;
        slow_q <= 4'($random(seed)) & 4'h7;
        @(posedge clk);
        fire_q <= 1'b0;
    endtask : trip

    task automatic pulse_ext(input logic [3:0] lim);
        @(posedge clk);
        ext_q <= 1'b1;
        @(posedge clk);
        ext_q <= 1'b0;
        tick(4);
        chk(32'(attempts_left_o), 32'(lim));
    endtask : pulse_ext

    task automatic restart(input logic [15:0] t, input int d, input logic [3:0] left);
        int n;
        logic [12:0] tl;
        n = 0;
        tl = '0;
        trip(t);
        tick(2);
        chk(32'(pending_o), 32'h1);
        while (drv.all_clear !== 1'b1) @(negedge clk);
        while (restart_req_o !== 1'b1) begin
            @(negedge clk);
            n++;
            if (tl == '0) tl = time_left_o;
        end
        chk(32'(tl), 32'(d));
        chk(32'(n >= (d - 1) * TK && n <= d * TK + 6), 32'h1);
        chk(32'(restart_in_progress_flag), 32'h1);
        chk(32'(pending_o), 32'h0);
        while (restart_req_o === 1'b1) @(negedge clk);
        tick(2);
        chk(32'(attempts_left_o), 32'(left));
    endtask : restart

    task automatic lockout(input logic [15:0] t, input logic [3:0] left);
        trip(t);
        tick(6);
        chk(32'(pending_o), 32'h0);
        chk(32'(restart_req_o), 32'h0);
        wb(1'b0, `TARS_OFS_STATUS, {20'h0, left, 8'h04});
    endtask : lockout

    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] ofs [9];
        logic [31:0] rv [9];
        logic [12:0] tl;
        int n;
        int idx;
        ofs = '{`TARS_OFS_CTRL, `TARS_OFS_LIMIT, `TARS_OFS_MASK_A, `TARS_OFS_MASK_B, `TARS_OFS_INIT_A,
                `TARS_OFS_ATT_A, `TARS_OFS_INIT_B, `TARS_OFS_IRQ_MASK, 8'h30};
        rv = '{32'h0, 32'h5, 32'h0, 32'h0, 32'h64, 32'h64, 32'h1, 32'h0, 32'h0};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk(32'(attempts_left_o), 32'h5);
        wb(1'b1, 8'h30, 32'hFFFF);
        for (int i = 0; i < 9; i++) wb(1'b0, ofs[i], rv[i]);
        wb(1'b1, `TARS_OFS_LIMIT, 32'h0);
        wb(1'b0, `TARS_OFS_LIMIT, 32'h1);
        wb(1'b1, `TARS_OFS_LIMIT, 32'hF);
        wb(1'b0, `TARS_OFS_LIMIT, 32'hA);
        wb(1'b1, `TARS_OFS_LIMIT, 32'h5);
        wb(1'b1, `TARS_OFS_INIT_B, 32'h1FFF);
        wb(1'b0, `TARS_OFS_INIT_B, 32'h1770);
        wb(1'b1, `TARS_OFS_MASK_A, 32'h0009);
        wb(1'b1, `TARS_OFS_MASK_B, 32'h0028);
        lockout(16'h0008, 4'h5);
        pulse_ext(4'h5);
        for (int i = 1; i < 8; i++) wb(1'b1, ofs[i], i == 1 ? 32'h2 : i == 4 ? 32'h2 : i == 5 ? 32'h6 :
                                          i == 6 ? 32'h9 : i == 7 ? 32'h2 : i == 2 ? 32'h9 : 32'h28);
        wb(1'b1, `TARS_OFS_ATT_B, 32'h3);
        wb(1'b1, `TARS_OFS_CTRL, 32'h1);
        restart(16'h0008, 2, 4'h1);
        restart(16'h0001, 6, 4'h0);
        lockout(16'h0001, 4'h0);
        chk(32'(irq_o), 32'h1);
        wb(1'b1, `TARS_OFS_IRQ_STAT, 32'h7);
        tick(3);
        chk(32'(irq_o), 32'h0);
        pulse_ext(4'h2);
        restart(16'h0020, 9, 4'h1);
        restart(16'h0020, 3, 4'h0);
        pulse_ext(4'h2);
        wb(1'b1, `TARS_OFS_INIT_A, 32'h14);
        trip(16'h0001);
        while (time_left_o === 13'h0) @(negedge clk);
        tl = time_left_o;
        wb(1'b1, `TARS_OFS_ATT_A, 32'h1770);
        wb(1'b1, `TARS_OFS_INIT_A, 32'h1770);
        tick(1);
        chk(32'(time_left_o <= tl && time_left_o !== 13'h0), 32'h1);
        while (restart_req_o !== 1'b1) @(negedge clk);
        while (restart_req_o === 1'b1) @(negedge clk);
        // 4 x 1000 ticks outlasts the 3000-tick floor, so the longer one must win
        wb(1'b1, `TARS_OFS_ATT_A, 32'h3E8);
        wb(1'b1, `TARS_OFS_IRQ_STAT, 32'h7);
        wb(1'b1, `TARS_OFS_IRQ_MASK, 32'h4);
        n = 0;
        while (attempts_left_o !== 4'h2 && n < 17000) begin
            @(negedge clk);
            n++;
        end
        chk(32'(n > 15800 && n < 16050), 32'h1);
        tick(2);
        chk(32'(irq_o), 32'h1);
        wb(1'b0, `TARS_OFS_IRQ_STAT, 32'h4);
        @(posedge clk);
        comms_q <= 1'b1;
        lockout(16'h0008, 4'h2);
        @(posedge clk);
        comms_q <= 1'b0;
        pulse_ext(4'h2);
        repeat (3) begin
            idx = int'($random(seed)) & 15;
            while (((32'h29 >> idx) & 1) == 1) idx = (idx + 1) % 16;
            lockout(16'(1 << idx), 4'h2);
            pulse_ext(4'h2);
        end
        summarize();
    end
endmodule : tars_top_bench
